// ===== hw/pps_defines.svh
// Purpose: constants for the power path selector
// Assumes: 100 MHz mclk, register port driven by the serial engine
// Notes:
// Functional notes
// R1: rail source chosen from comparators plus control register 0x4C
// R2: automatic priority is adapter, then USB, then battery
// R3: automatic bit 0 clear connects battery even with inputs present
// R4: automatic clear and no battery leaves the rail unconnected
// R5: suspend bit 7 ignores USB; only adapter or battery feed rail; fault recovery still enables the USB pull-up under suspend
// R6: limit from select bit 2 and mode bit 1: 100mA, 500mA, high
// R7: rail short or battery over-current is a fault; all switches off
// R8: switch table per fault, automatic, detect, suspend, lockout
// R9: fault recovery: adapter pull-up, else USB pull-up, else 30mA
// R10: overload with battery present adds battery switch (supplement)
// R11: input detected above battery margin and below over-voltage
// R12: switch-on flags at 0xB9, detect and over-voltage flags at 0xBB
// R13: linear charger kept active in sleep, fed from second buck
// R14: stand-alone arrangement holds buck two at the programmed code
// R15: pre-regulator fast charge tracks battery plus 0.26V; code rounds up to 11 steps of 25mV, so adds 275mV
// R16: battery power, pre-charge or no thermistor revert to code
// R17: host sets buck two about 250mV above charge regulation voltage
// R18: write commits at data acknowledge end; stop or start cancels
// R19: comparator inputs synchronised before switch selection
`ifndef PPS_DEFINES_SVH
`define PPS_DEFINES_SVH
// ****************************************
// register map
// ****************************************
`define PPS_ADDR_CTRL     8'h4c
`define PPS_ADDR_SWSTAT   8'hb9
`define PPS_ADDR_DETSTAT  8'hbb
`define PPS_CTRL_RESET    8'h01
`define PPS_CTRL_WMASK    8'hef
// ****************************************
// control fields
// ****************************************
`define PPS_B_AUTO        0
`define PPS_B_MODE        1
`define PPS_B_LIMIT       2
`define PPS_B_SUSP        7
// ****************************************
// status fields
// ****************************************
`define PPS_B_BATON       0
`define PPS_B_ACON        1
`define PPS_B_USBON       2
`define PPS_B_LOW_RAIL_FLAG      0
`define PPS_B_ADAPTER_PRESENT_FLAG       1
`define PPS_B_USB_PRESENT_FLAG      2
`define PPS_B_ACOVP       3
`define PPS_B_USBOVP      4
// ****************************************
// analog figures
// ****************************************
`define PPS_TRACK_MV      260
`define PPS_ISRC_MA       30
`endif

// ===== hw/pps_pkg.sv
// Purpose: shared types of the power path selector
// Assumes: nothing
// Notes: limit codes drive the USB current-limit trim
package pps_pkg;
  typedef enum logic [1:0] {
    PPS_LIM_100 = 2'b00,
    PPS_LIM_500 = 2'b01,
    PPS_LIM_HIGH = 2'b10
  } pps_lim_t;
  typedef enum logic [1:0] {
    PPS_SRC_NONE = 2'b00,
    PPS_SRC_AC   = 2'b01,
    PPS_SRC_USB  = 2'b10,
    PPS_SRC_BAT  = 2'b11
  } pps_src_t;
endpackage

// ===== hw/pps_ctrl_if.sv
// Purpose: control bits and status bytes between register port and core
// Assumes: single mclk domain
// Notes: none
`timescale 1ns/1ns
`default_nettype none
interface pps_ctrl_if;
  logic [7:0] ctrl;
  logic [7:0] swStat;
  logic [7:0] detStat;
  modport regs (output ctrl, input swStat, input detStat);
  modport core (input ctrl, output swStat, output detStat);
endinterface
`default_nettype wire

// ===== hw/pps_sync.sv
// Purpose: two-flop synchroniser for a bundle of levels
// Assumes: inputs are slow analog comparator levels
// Notes: first stage read only by the second
`timescale 1ns/1ns
`default_nettype none
module pps_sync #(
  parameter int W = 1
) (
  input  wire logic         mclk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] meta_q;

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_q <= '0;
      dout   <= '0;
    end
    else
    begin
      meta_q <= din; // R19
      dout   <= meta_q; // R19
    end
  end
endmodule
`default_nettype wire

// ===== hw/pps_regs.sv
// Purpose: control register write and status read on the register port
// Assumes: engine strobes data byte, then ack end or cancel
// Notes: unmapped reads return zero, unmapped writes are dropped
`timescale 1ns/1ns
`default_nettype none
`include "pps_defines.svh"
module pps_regs
  import pps_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       rst_n,
  input  wire logic [7:0] regAddr,
  input  wire logic [7:0] regWrData,
  input  wire logic       regDataStb,
  input  wire logic       regAckDone,
  input  wire logic       regCancel,
  output logic      [7:0] regRdData,
  pps_ctrl_if.regs        cif
);
  logic [7:0] ctrl_q;
  logic [7:0] pend_q;
  logic       pendV_q;

  // a held byte only lands when its acknowledge completes
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pendV_q <= 1'b0;
      pend_q  <= 8'h00;
    end
    else if (regDataStb && regAddr == `PPS_ADDR_CTRL)
    begin
      pendV_q <= 1'b1;
      pend_q  <= regWrData;
    end
    else if (regCancel || regAckDone)
      pendV_q <= 1'b0; // R18
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      ctrl_q <= `PPS_CTRL_RESET;
    else if (regAckDone && pendV_q && !regCancel)
      ctrl_q <= pend_q & `PPS_CTRL_WMASK; // R18
  end

  assign cif.ctrl = ctrl_q;

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      regRdData <= 8'h00;
    else
      case (regAddr)
        `PPS_ADDR_CTRL:    regRdData <= ctrl_q;
        `PPS_ADDR_SWSTAT:  regRdData <= cif.swStat; // R12
        `PPS_ADDR_DETSTAT: regRdData <= cif.detStat; // R12
        default:           regRdData <= 8'h00;
      endcase
  end
endmodule
`default_nettype wire

// ===== hw/pps_power_path_selector.sv
// Purpose: power path switch selection, fault recovery, limits, buck two
// Assumes: comparator levels arrive asynchronously; charger phases on pins
// Notes: all switch enables are flops, so they never glitch
`timescale 1ns/1ns
`default_nettype none
`include "pps_defines.svh"
module pps_power_path_selector
  import pps_pkg::*;
#(
  parameter int CODE_W  = 5,
  parameter int STEP_MV = 25,
  parameter int BASE_MV = 1000
) (
  input  wire logic              mclk,
  input  wire logic              rst_n,
  input  wire logic [7:0]        regAddr,
  input  wire logic [7:0]        regWrData,
  input  wire logic              regDataStb,
  input  wire logic              regAckDone,
  input  wire logic              regCancel,
  output logic      [7:0]        regRdData,
  input  wire logic              acAboveBat,
  input  wire logic              acAboveOvp,
  input  wire logic              usbAboveBat,
  input  wire logic              usbAboveOvp,
  input  wire logic              sysShort,
  input  wire logic              batOverCurrent,
  input  wire logic              sysBelowSupp,
  input  wire logic              batPresent,
  input  wire logic              undervoltageLockout,
  input  wire logic              sleepState,
  input  wire logic              chargerOnReq,
  input  wire logic              preRegulatorMode,
  input  wire logic              fastCharge,
  input  wire logic              preCharge,
  input  wire logic              thermistorAbsent,
  input  wire logic [CODE_W-1:0] buckTwoVoltageCode,
  input  wire logic [CODE_W-1:0] batVoltCode,
  output logic                   acSwitchEn,
  output logic                   usbSwitchEn,
  output logic                   batSwitchEn,
  output logic                   acPullupEn,
  output logic                   usbPullupEn,
  output logic                   currentSourceEn,
  output logic                   faultFlag,
  output pps_lim_t               usb_current_select,
  output pps_src_t               railSource,
  output logic                   chargerEn,
  output logic                   chargerFromBuckTwo,
  output logic      [CODE_W-1:0] buckTwoTarget
);
  // ****************************************
  // constants
  // ****************************************
  localparam int TRACK_STEPS = (`PPS_TRACK_MV + STEP_MV - 1) / STEP_MV;
  localparam logic [CODE_W:0] TRACK_OFS = (CODE_W + 1)'(TRACK_STEPS);
  localparam logic [CODE_W:0] CODE_MAX = {1'b0, {CODE_W{1'b1}}};
  localparam int NSYNC = 15;

  // ****************************************
  // register port
  // ****************************************
  pps_ctrl_if cif ();

  pps_regs u_regs (
    .mclk       (mclk),
    .rst_n      (rst_n),
    .regAddr    (regAddr),
    .regWrData  (regWrData),
    .regDataStb (regDataStb),
    .regAckDone (regAckDone),
    .regCancel  (regCancel),
    .regRdData  (regRdData),
    .cif        (cif)
  );

  // ****************************************
  // input synchronisers
  // ****************************************
  logic [NSYNC-1:0] rawIn;
  logic [NSYNC-1:0] syncIn;

  assign rawIn = {acAboveBat, acAboveOvp, usbAboveBat, usbAboveOvp,
                  sysShort, batOverCurrent, sysBelowSupp, batPresent,
                  undervoltageLockout, sleepState, chargerOnReq,
                  preRegulatorMode, fastCharge, preCharge,
                  thermistorAbsent};

  pps_sync #(
    .W (NSYNC)
  ) u_sync (
    .mclk  (mclk),
    .rst_n (rst_n),
    .din   (rawIn),
    .dout  (syncIn)
  );

  logic acBat;
  logic acOvp;
  logic usbBat;
  logic usbOvp;
  logic sysSh;
  logic batOc;
  logic sysLow;
  logic batIn;
  logic undervoltage_lockout;
  logic sleepS;
  logic chgReq;
  logic preReg;
  logic fastChg;
  logic preChg;
  logic tsGone;

  assign {acBat, acOvp, usbBat, usbOvp, sysSh, batOc, sysLow, batIn,
          undervoltage_lockout, sleepS, chgReq, preReg, fastChg, preChg, tsGone} = syncIn; // R19

  // ****************************************
  // control fields
  // ****************************************
  logic autoSel;
  logic usb_input_suspend;
  logic limSel;
  logic limMode;

  assign autoSel = cif.ctrl[`PPS_B_AUTO];
  assign usb_input_suspend = cif.ctrl[`PPS_B_SUSP];
  assign limSel  = cif.ctrl[`PPS_B_LIMIT];
  assign limMode = cif.ctrl[`PPS_B_MODE];

  // ****************************************
  // detection
  // ****************************************
  // an input beyond the over-voltage level is never used as a source
  function automatic logic detected(input logic aboveBat, input logic ovp);
    detected = aboveBat && !ovp;
  endfunction

  logic adapter_present_flag;
  logic usb_present_flag;
  logic fault;
  logic usbUsable;

  assign adapter_present_flag     = detected(acBat, acOvp); // R11
  assign usb_present_flag    = detected(usbBat, usbOvp); // R11
  assign fault     = sysSh || batOc; // R7
  assign usbUsable = usb_present_flag && !usb_input_suspend; // R5

  // ****************************************
  // source selection
  // ****************************************
  pps_src_t srcD;

  always_comb
  begin
    srcD = PPS_SRC_NONE;
    if (undervoltage_lockout || fault)
      srcD = PPS_SRC_NONE; // R8
    else if (!autoSel)
      srcD = batIn ? PPS_SRC_BAT : PPS_SRC_NONE; // R3 R4
    else if (adapter_present_flag)
      srcD = PPS_SRC_AC; // R2
    else if (usbUsable)
      srcD = PPS_SRC_USB; // R2 R5
    else if (batIn)
      srcD = PPS_SRC_BAT; // R2
    else
      srcD = PPS_SRC_NONE; // R5
  end

  // battery helps an overloaded input only while it is not itself tripped
  logic suppNeed;

  assign suppNeed = batIn && sysLow && !batOc &&
                    (srcD == PPS_SRC_AC || srcD == PPS_SRC_USB); // R10

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      acSwitchEn  <= 1'b0;
      usbSwitchEn <= 1'b0;
      batSwitchEn <= 1'b0;
      railSource  <= PPS_SRC_NONE;
    end
    else
    begin
      acSwitchEn  <= (srcD == PPS_SRC_AC); // R1 R8
      usbSwitchEn <= (srcD == PPS_SRC_USB); // R1 R8
      batSwitchEn <= (srcD == PPS_SRC_BAT) || suppNeed; // R8 R10
      railSource  <= srcD;
    end
  end

  // ****************************************
  // fault recovery
  // ****************************************
  // lockout wins over the fault path: nothing feeds the rail then
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      faultFlag       <= 1'b0;
      acPullupEn      <= 1'b0;
      usbPullupEn     <= 1'b0;
      currentSourceEn <= 1'b0;
    end
    else
    begin
      faultFlag       <= fault; // R7
      acPullupEn      <= fault && !undervoltage_lockout && adapter_present_flag; // R9
      usbPullupEn     <= fault && !undervoltage_lockout && !adapter_present_flag && usb_present_flag; // R9
      currentSourceEn <= fault && !undervoltage_lockout && !adapter_present_flag && !usb_present_flag; // R9
    end
  end

  // ****************************************
  // usb current limit
  // ****************************************
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      usb_current_select <= PPS_LIM_100;
    else if (limMode)
      usb_current_select <= PPS_LIM_HIGH; // R6
    else if (limSel)
      usb_current_select <= PPS_LIM_500; // R6
    else
      usb_current_select <= PPS_LIM_100; // R6
  end

  // ****************************************
  // status bytes
  // ****************************************
  always_comb
  begin
    cif.swStat = 8'h00;
    cif.swStat[`PPS_B_BATON] = batSwitchEn; // R12
    cif.swStat[`PPS_B_ACON]  = acSwitchEn; // R12
    cif.swStat[`PPS_B_USBON] = usbSwitchEn; // R12
  end

  always_comb
  begin
    cif.detStat = 8'h00;
    cif.detStat[`PPS_B_LOW_RAIL_FLAG] = sysLow; // R12
    cif.detStat[`PPS_B_ADAPTER_PRESENT_FLAG]  = adapter_present_flag; // R12
    cif.detStat[`PPS_B_USB_PRESENT_FLAG] = usb_present_flag; // R12
    cif.detStat[`PPS_B_ACOVP]  = acOvp; // R11 R12
    cif.detStat[`PPS_B_USBOVP] = usbOvp; // R11 R12
  end

  // ****************************************
  // charger and buck two
  // ****************************************
  // the buck-fed charger arrangement is fixed in this build
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      chargerEn          <= 1'b0;
      chargerFromBuckTwo <= 1'b1;
    end
    else
    begin
      chargerEn          <= chgReq || sleepS; // R13
      chargerFromBuckTwo <= 1'b1; // R13
    end
  end

  // saturate rather than wrap: a wrapped code would collapse the rail
  function automatic logic [CODE_W-1:0] trackCode(input logic [CODE_W-1:0] b);
    logic [CODE_W:0] s;
    s = {1'b0, b} + TRACK_OFS;
    trackCode = (s > CODE_MAX) ? CODE_MAX[CODE_W-1:0] : s[CODE_W-1:0];
  endfunction

  logic onBattery;
  logic tracking;

  assign onBattery = (srcD == PPS_SRC_BAT) || !(adapter_present_flag || usb_present_flag);
  assign tracking  = preReg && fastChg && !onBattery &&
                     !preChg && !tsGone; // R15 R16

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      buckTwoTarget <= '0;
    else if (tracking)
      buckTwoTarget <= trackCode(batVoltCode); // R15
    else
      buckTwoTarget <= buckTwoVoltageCode; // R14 R16
  end
endmodule
`default_nettype wire

// ===== dv/pps_props.sv
// Purpose: concurrent checks on the selector ports
// Assumes: pin levels reach the outputs three edges after a change
// Notes: okQ holds checks off until the sync pipe has refilled
`timescale 1ns/1ns
`default_nettype none
module pps_props
  import pps_pkg::*;
(
  input wire logic     mclk,
  input wire logic     rst_n,
  input wire logic     acAboveBat,
  input wire logic     acAboveOvp,
  input wire logic     sysShort,
  input wire logic     batOverCurrent,
  input wire logic     undervoltageLockout,
  input wire logic     sleepState,
  input wire logic     chargerOnReq,
  input wire logic     acSwitchEn,
  input wire logic     usbSwitchEn,
  input wire logic     batSwitchEn,
  input wire logic     acPullupEn,
  input wire logic     usbPullupEn,
  input wire logic     currentSourceEn,
  input wire logic     faultFlag,
  input wire pps_src_t railSource,
  input wire logic     chargerEn
);
  logic [1:0] fillQ;
  wire        okQ = fillQ == 2'h3;
  // pins seen before release would leak through $past otherwise
  always_ff @(posedge mclk or negedge rst_n)
    if (!rst_n)
      fillQ <= 2'h0;
    else if (fillQ != 2'h3)
      fillQ <= fillQ + 2'h1;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  a_fault_flag: assert property (okQ |-> faultFlag == $past(sysShort | batOverCurrent, 3))
    else $error("fault flag does not follow short or over-current");
  a_fault_off: assert property (faultFlag |-> !(acSwitchEn | usbSwitchEn | batSwitchEn))
    else $error("switch on during fault");
  a_lockout_off: assert property (okQ && $past(undervoltageLockout, 3) |->
    !(acSwitchEn | usbSwitchEn | batSwitchEn | acPullupEn | usbPullupEn | currentSourceEn))
    else $error("output active under lockout");
  a_one_input: assert property (!(acSwitchEn && usbSwitchEn))
    else $error("both input switches on");
  a_ac_first: assert property (okQ && $past(acAboveBat && !acAboveOvp && !sysShort
    && !batOverCurrent && !undervoltageLockout, 3) |-> !usbSwitchEn)
    else $error("usb switch on while adapter valid");
  a_ovp_block: assert property (okQ && $past(acAboveOvp, 3) |-> !acSwitchEn && !acPullupEn)
    else $error("adapter used above over-voltage");
  a_recov_one: assert property ((acPullupEn || usbPullupEn || currentSourceEn) |->
    faultFlag && $onehot({acPullupEn, usbPullupEn, currentSourceEn}))
    else $error("recovery source wrong");
  a_rail_ac: assert property (railSource == PPS_SRC_AC |-> acSwitchEn && !usbSwitchEn)
    else $error("rail source adapter without adapter switch");
  a_rail_bat: assert property (railSource == PPS_SRC_BAT |->
    batSwitchEn && !acSwitchEn && !usbSwitchEn)
    else $error("rail source battery without battery switch");
  a_charger_en: assert property (okQ |-> chargerEn == $past(sleepState || chargerOnReq, 3))
    else $error("charger enable wrong");
  c_fault: cover property (faultFlag && currentSourceEn);
  c_supp: cover property (acSwitchEn && batSwitchEn);
  c_usb: cover property (usbSwitchEn && batSwitchEn);
endmodule
bind pps_power_path_selector pps_props i_props (
  .mclk(mclk), .rst_n(rst_n), .acAboveBat(acAboveBat), .acAboveOvp(acAboveOvp),
  .sysShort(sysShort), .batOverCurrent(batOverCurrent),
  .undervoltageLockout(undervoltageLockout), .sleepState(sleepState),
  .chargerOnReq(chargerOnReq), .acSwitchEn(acSwitchEn), .usbSwitchEn(usbSwitchEn),
  .batSwitchEn(batSwitchEn), .acPullupEn(acPullupEn), .usbPullupEn(usbPullupEn),
  .currentSourceEn(currentSourceEn), .faultFlag(faultFlag), .railSource(railSource),
  .chargerEn(chargerEn)
);
`default_nettype wire

// ===== dv/pps_host_model.sv
// Purpose: host side of the register port, one byte per write
// Assumes: strobes change just after a rising edge
// Notes: released data shows the inverse of the last byte
`timescale 1ns/1ns
`default_nettype none
module pps_host_model (
  input  wire logic       mclk,
  output logic      [7:0] regAddr,
  output logic      [7:0] regWrData,
  output logic            regDataStb,
  output logic            regAckDone,
  output logic            regCancel,
  input  wire logic [7:0] regRdData
);
  initial
  begin
    regAddr = 8'h00;
    regWrData = 8'h00;
    regDataStb = 1'b0;
    regAckDone = 1'b0;
    regCancel = 1'b0;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input bit drop);
    @(posedge mclk) #1;
    regAddr = a;
    regWrData = d;
    regDataStb = 1'b1;
    @(posedge mclk) #1;
    regDataStb = 1'b0;
    regWrData = ~d;
    regAckDone = !drop;
    regCancel = drop;
    @(posedge mclk) #1;
    regAckDone = 1'b0;
    regCancel = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk) #1;
    regAddr = a;
    repeat (2) @(posedge mclk);
    d = regRdData;
  endtask
endmodule
`default_nettype wire

// ===== dv/tb_power_path_selector.sv
// Purpose: self-checking bench of the power path selector
// Assumes: outputs settle within six edges of a pin change
// Notes: battery switch is a don't-care while no pack is present
`timescale 1ns/1ns
`default_nettype none
`include "pps_defines.svh"
module tb_power_path_selector
  import pps_pkg::*;
;
  logic            mclk = 1'b0;
  logic            rst_n = 1'b0;
  logic     [14:0] pins = 15'h0000;
  logic     [4:0]  code = 5'h00;
  logic     [4:0]  batV = 5'h00;
  logic     [7:0]  ctrl = 8'h01;
  logic     [7:0]  rdv;
  logic     [31:0] r;
  int              err_total = 0;
  int              cmp_count = 0;
  int              cyc = 0;
  wire logic [7:0] regAddr, regWrData, regRdData;
  wire logic       regDataStb, regAckDone, regCancel;
  wire logic       acSw, usbSw, batSw, acPu, usbPu, isrc, fault, chgEn, chgBuck;
  wire pps_lim_t   lim;
  wire pps_src_t   src;
  wire logic [4:0] tgt;
  pps_host_model i_host (.mclk(mclk), .regAddr(regAddr), .regWrData(regWrData),
    .regDataStb(regDataStb), .regAckDone(regAckDone), .regCancel(regCancel),
    .regRdData(regRdData));
  pps_power_path_selector i_dut (.mclk(mclk), .rst_n(rst_n), .regAddr(regAddr),
    .regWrData(regWrData), .regDataStb(regDataStb), .regAckDone(regAckDone),
    .regCancel(regCancel), .regRdData(regRdData), .acAboveBat(pins[0]),
    .acAboveOvp(pins[1]), .usbAboveBat(pins[2]), .usbAboveOvp(pins[3]),
    .sysShort(pins[4]), .batOverCurrent(pins[5]), .sysBelowSupp(pins[6]),
    .batPresent(pins[7]), .undervoltageLockout(pins[8]), .sleepState(pins[9]),
    .chargerOnReq(pins[10]), .preRegulatorMode(pins[11]), .fastCharge(pins[12]),
    .preCharge(pins[13]), .thermistorAbsent(pins[14]), .buckTwoVoltageCode(code),
    .batVoltCode(batV), .acSwitchEn(acSw), .usbSwitchEn(usbSw), .batSwitchEn(batSw),
    .acPullupEn(acPu), .usbPullupEn(usbPu), .currentSourceEn(isrc), .faultFlag(fault),
    .usb_current_select(lim), .railSource(src), .chargerEn(chgEn),
    .chargerFromBuckTwo(chgBuck), .buckTwoTarget(tgt));
  initial
    forever #5 mclk = ~mclk;
  // ****
  // reference and checks
  // ****
  function automatic logic [13:0] model(input logic [14:0] p, input logic [7:0] c);
    logic       acD, usD, sup, trk, bs;
    logic [5:0] s;
    logic [4:0] t;
    acD = p[0] & !p[1];
    usD = p[2] & !p[3];
    sup = p[7] & p[6];
    if (p[8])
      s = 6'h00;
    else if (p[4] | p[5])
      s = acD ? 6'h08 : usD ? 6'h10 : 6'h20;
    else if (!c[0])
      s = 6'h04;
    else if (acD)
      s = {3'h0, sup, 2'h1};
    else if (usD && !c[7])
      s = {3'h0, sup, 2'h2};
    else
      s = 6'h04;
    // battery power: battery is the source, or no input is detected
    bs = !p[8] & !(p[4] | p[5]) & p[7] & (!c[0] | !(acD | (usD & !c[7])));
    trk = p[11] & p[12] & !p[13] & !p[14] & !bs & (acD | usD);
    t = !trk ? code : (batV > 5'd20) ? 5'h1f : batV + 5'd11;
    return {t, c[1] ? 2'h2 : {1'b0, c[2]}, p[9] | p[10], s};
  endfunction
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      err_total++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic wctrl(input logic [7:0] a, input logic [7:0] d, input bit drop);
    i_host.wr(a, d, drop);
    if (a == `PPS_ADDR_CTRL && !drop)
      ctrl = d & `PPS_CTRL_WMASK;
    i_host.rd(`PPS_ADDR_CTRL, rdv);
    check("control", 16'(rdv), 16'(ctrl));
  endtask
  task automatic apply(input logic [14:0] p);
    logic [13:0] e;
    logic [13:0] m;
    @(posedge mclk) #1;
    pins = p;
    code = 5'($urandom);
    batV = 5'($urandom);
    repeat (6) @(posedge mclk);
    e = model(p, ctrl);
    m = p[7] ? 14'h3fff : 14'h3ffb;
    check("outputs", 16'({tgt, lim, chgEn, isrc, usbPu, acPu, batSw, usbSw, acSw} & m),
      16'(e & m));
    check("faultFlag", 16'(fault), 16'(p[4] | p[5]));
    check("railSource", 16'(src), 16'(e[0] ? 2'h1 : e[1] ? 2'h2 : {2{e[2] & p[7]}}));
    i_host.rd(`PPS_ADDR_SWSTAT, rdv);
    check("switch status", 16'(rdv & {7'h7f, p[7]}), 16'({e[1:0], e[2] & p[7]}));
    i_host.rd(`PPS_ADDR_DETSTAT, rdv);
    check("detect status", 16'(rdv),
      16'({p[3], p[1], p[2] & !p[3], p[0] & !p[1], p[6]}));
  endtask
  always @(posedge mclk)
  begin
    cyc++;
    // ceiling well above the roughly 4700 cycles of the sequence
    if (cyc == 30000)
    begin
      err_total++;
      conclude();
    end
  end
  // ****
  // sequence
  // ****
  logic [14:0] corner [9] = '{15'h0084, 15'h0011, 15'h0024, 15'h0010, 15'h00c1,
    15'h0087, 15'h0101, 15'h1881, 15'h0001};
  logic [7:0]  modes [5] = '{8'h01, 8'h81, 8'h00, 8'h83, 8'h05};
  initial
  begin
    void'($urandom(32'h4775));
    repeat (16) @(posedge mclk);
    #1 rst_n = 1'b1;
    @(posedge mclk) #1;
    check("chargerFromBuckTwo", 16'(chgBuck), 16'h0001);
    i_host.rd(`PPS_ADDR_CTRL, rdv);
    check("reset control", 16'(rdv), 16'(`PPS_CTRL_RESET));
    $display("test reset done");
    wctrl(`PPS_ADDR_CTRL, 8'hfe, 1'b1);
    wctrl(`PPS_ADDR_SWSTAT, 8'h00, 1'b0);
    wctrl(`PPS_ADDR_CTRL, 8'h90, 1'b0);
    i_host.rd(8'h00, rdv);
    check("unmapped read", 16'(rdv), 16'h0000);
    $display("test register port done");
    foreach (modes[i])
    begin
      wctrl(`PPS_ADDR_CTRL, modes[i], 1'b0);
      foreach (corner[j])
        apply(corner[j]);
    end
    $display("test corners done");
    for (int k = 0; k < 300; k++)
    begin
      if (k % 16 == 0)
        wctrl(`PPS_ADDR_CTRL, 8'($urandom), 1'b0);
      r = $urandom;
      // faults and lockout kept rare so the switch table is reached
      if (r[31:30] != 2'h0)
        r[5:4] = 2'h0;
      if (r[29:27] != 3'h0)
        r[8] = 1'b0;
      apply(r[14:0]);
    end
    $display("test random done");
    conclude();
  end
endmodule
`default_nettype wire
